// ### common/sapc_regs.svh
`ifndef SAPC_REGS_SVH
`define SAPC_REGS_SVH
`define SAPC_A_CFG1 8'h10
`define SAPC_A_CFG2 8'h14
`define SAPC_A_CFG3 8'h18
`define SAPC_A_CFG4 8'h1C
`define SAPC_A_DIN1L 8'h34
`define SAPC_A_DIN3L 8'h44
`define SAPC_A_DIN1R 8'h54
`define SAPC_A_DIN3R 8'h64
`define SAPC_A_DIN2 8'h74
`define SAPC_A_URX1 8'h88
`define SAPC_A_QRX1 8'h8C
`define SAPC_A_URX2 8'hD8
`define SAPC_A_QRX2 8'hDC
`define SAPC_A_IEN1 8'h94
`define SAPC_A_ISTAT1 8'h98
`define SAPC_A_ICLR1 8'h9C
`define SAPC_A_ISTAT2 8'hE0
`define SAPC_A_ICLR2 8'hE0
`define SAPC_A_IEN2 8'hE4
`define SAPC_CFG_RESET 32'h00000800
`define SAPC_CFG_MASK 32'h000FFFFF
`define SAPC_CFG4_MASK 32'h0000F000
`define SAPC_F_WCINV 1
`define SAPC_F_BPW 2
`define SAPC_F_MODE 5
`define SAPC_F_SIZE 6
`define SAPC_F_SRC 8
`define SAPC_F_FIFO 11
`define SAPC_F_CSEL 12
`define SAPC_F_SRCHI 16
`define SAPC_F_CFPOS 17
`define SAPC_F_CDINS 18
`define SAPC_BPW_64 3'h4
`define SAPC_BPW_48 3'h2
`define SAPC_HALF_64 6'h20
`define SAPC_HALF_48 6'h18
`define SAPC_HALF_32 6'h10
`define SAPC_SIZE_ZERO 2'h3
`define SAPC_SRC_ZERO 4'h0
`define SAPC_CSEL_EXT 4'h0
`define SAPC_CSEL_DIV2 4'hC
`define SAPC_CSEL_FOL1 4'h8
`define SAPC_CSEL_FOL2 4'h9
`define SAPC_CSEL_FOL3 4'hA
`define SAPC_DV24 5'h18
`define SAPC_DV16 5'h10
`define SAPC_DV12 5'h0C
`define SAPC_DV8 5'h08
`define SAPC_DV6 5'h06
`define SAPC_DV4 5'h04
`define SAPC_DV3 5'h03
`define SAPC_DV2 5'h02
`define SAPC_CF_AFTER 6'h01
`define SAPC_CF_BEFORE 6'h06
`define SAPC_B_DIN1F 0
`define SAPC_B_DIN2F 1
`define SAPC_B_TXE3 2
`define SAPC_B_TXE2 3
`define SAPC_B_TXE1 4
`define SAPC_B_DIN3F 5
`define SAPC_B_DIN3R 6
`define SAPC_B_RX2ERR 7
`define SAPC_B_TICK 8
`define SAPC_B_DIN2R 9
`define SAPC_B_DIN2UO 10
`define SAPC_B_DIN1R 11
`define SAPC_B_DIN1UO 12
`define SAPC_B_UQERR 13
`define SAPC_B_UQSYNC 14
`define SAPC_B_QOVR 15
`define SAPC_B_QFULL 16
`define SAPC_B_UOVR 17
`define SAPC_B_UFULL2 18
`define SAPC_B_PAR2 22
`define SAPC_B_SYM2 23
`define SAPC_B_VAL2 24
`define SAPC_B_CNEW2 25
`define SAPC_STAT1_MASK 32'h0003FFFF
`define SAPC_STAT2_MASK 32'h03C7E000
`define SAPC_CLR1_MASK 32'h0002FFC0
`define SAPC_CLR2_MASK 32'h03C2E000
`endif

// ### common/sapc_pkg.sv
package sapc_pkg;
  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic word_clock_o;
    logic word_clock_oe;
  } sapc_pins_t;

  typedef struct packed {
    logic [2:0] data_in_full;
    logic [2:0] tx_empty;
    logic [1:0] data_in_under_over;
    logic [2:0] data_in_resync;
    logic tick_event;
    logic rx1_u_overrun;
    logic rx1_q_full;
    logic rx1_q_overrun;
    logic rx1_uq_sync;
    logic rx1_uq_frame_err;
    logic [2:0] rx2_uq_combined_err;
    logic rx2_new_c_channel;
    logic rx2_validity_clear;
    logic rx2_symbol_err;
    logic rx2_parity_err;
    logic rx2_u_full;
    logic rx2_u_overrun;
    logic rx2_q_full;
    logic rx2_q_overrun;
    logic rx2_uq_sync;
    logic rx2_uq_frame_err;
  } sapc_evt_t;

  typedef enum logic [1:0] {FIFO_HELD, FIFO_ARMED, FIFO_RUN} sapc_fifo_st_t;
endpackage

// ### design/sapc_top.sv
`timescale 1ns/10ps
`include "sapc_regs.svh"
module sapc_top #(
  parameter int NCLK = 4,
  parameter int NTX = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic audio_ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [NCLK-1:0] sclk_in,
  input wire logic [NCLK-1:0] word_clock_in,
  output sapc_pkg::sapc_pins_t [NCLK-1:0] pins,
  output logic [NCLK-1:0] word_clock,
  output logic [NCLK-1:0] bit_fall,
  input wire logic correction_flag_in,
  output logic correction_flag_q,
  output logic cd_flag_insert,
  input wire sapc_pkg::sapc_evt_t evt,
  input wire logic [2:0] tx_fifo_wr,
  output logic [NTX-1:0] tx_fifo_reset,
  output logic [NTX-1:0] tx_zero,
  output logic [NTX-1:0][3:0] transmit_source_select,
  output logic [2:0] port_zero,
  output logic [2:0] port_eiaj,
  output logic [31:0] irq_req1,
  output logic [31:0] irq_req2
);

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [31:0] cfg_q [NCLK];
  logic [31:0] ien1_q, ien2_q, stat1_q, stat2_q;
  logic rd_din1, rd_din2, rd_din3, rd_q1, rd_u2, rd_q2;

  assign rd_din1 = rd && (addr == `SAPC_A_DIN1L || addr == `SAPC_A_DIN1R);
  assign rd_din3 = rd && (addr == `SAPC_A_DIN3L || addr == `SAPC_A_DIN3R);
  assign rd_din2 = rd && addr == `SAPC_A_DIN2;
  assign rd_q1 = rd && addr == `SAPC_A_QRX1;
  assign rd_u2 = rd && addr == `SAPC_A_URX2;
  assign rd_q2 = rd && addr == `SAPC_A_QRX2;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCLK; i++) begin
        cfg_q[i] <= `SAPC_CFG_RESET;
      end
    end else if (wr) begin
      unique case (addr)
        `SAPC_A_CFG1: cfg_q[0] <= wdata & `SAPC_CFG_MASK;
        `SAPC_A_CFG2: cfg_q[1] <= wdata & `SAPC_CFG_MASK;
        `SAPC_A_CFG3: cfg_q[2] <= wdata & `SAPC_CFG_MASK;
        `SAPC_A_CFG4: cfg_q[3] <= (wdata & `SAPC_CFG4_MASK) | `SAPC_CFG_RESET;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ien1_q <= 32'h00000000;
      ien2_q <= 32'h00000000;
    end else if (wr) begin
      if (addr == `SAPC_A_IEN1) begin
        ien1_q <= wdata & `SAPC_STAT1_MASK;
      end
      if (addr == `SAPC_A_IEN2) begin
        ien2_q <= wdata & `SAPC_STAT2_MASK;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      unique case (addr)
        `SAPC_A_CFG1: rdata <= cfg_q[0];
        `SAPC_A_CFG2: rdata <= cfg_q[1];
        `SAPC_A_CFG3: rdata <= cfg_q[2];
        `SAPC_A_CFG4: rdata <= cfg_q[3] & `SAPC_CFG4_MASK;
        `SAPC_A_IEN1: rdata <= ien1_q;
        `SAPC_A_IEN2: rdata <= ien2_q;
        `SAPC_A_ISTAT1: rdata <= stat1_q;
        `SAPC_A_ISTAT2: rdata <= stat2_q;
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      // read data last one cycle only
      rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit FIFO control for ports 1 and 2
  sapc_pkg::sapc_fifo_st_t fst_q [NTX];
  logic [NTX-1:0] src_zero;

  for (genvar t = 0; t < NTX; t++) begin : g_tx
    logic [3:0] src;
    logic ctl;
    assign src = {cfg_q[t][`SAPC_F_SRCHI], cfg_q[t][`SAPC_F_SRC +: 3]};
    assign ctl = cfg_q[t][`SAPC_F_FIFO];
    assign src_zero[t] = src == `SAPC_SRC_ZERO;

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        fst_q[t] <= sapc_pkg::FIFO_HELD;
      end else begin
        unique case (fst_q[t])
          sapc_pkg::FIFO_HELD: if (!ctl) fst_q[t] <= sapc_pkg::FIFO_ARMED;
          sapc_pkg::FIFO_ARMED: begin
            if (ctl) begin
              fst_q[t] <= sapc_pkg::FIFO_HELD;
            end else if (tx_fifo_wr[t]) begin
              fst_q[t] <= sapc_pkg::FIFO_RUN;
            end
          end
          sapc_pkg::FIFO_RUN: if (ctl) fst_q[t] <= sapc_pkg::FIFO_HELD;
        endcase
      end
    end

    // clock select is sampled by the clock logic at all times; changing it
    // outside FIFO reset gives glitchy bit clocks
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        tx_fifo_reset[t] <= 1'b1;
        tx_zero[t] <= 1'b1;
        transmit_source_select[t] <= 4'h0;
      end else begin
        tx_fifo_reset[t] <= fst_q[t] != sapc_pkg::FIFO_RUN;
        tx_zero[t] <= src_zero[t];
        transmit_source_select[t] <= src;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_zero <= 3'h0;
      port_eiaj <= 3'h0;
      cd_flag_insert <= 1'b0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        port_zero[p] <= cfg_q[p][`SAPC_F_SIZE +: 2] == `SAPC_SIZE_ZERO;
        port_eiaj[p] <= cfg_q[p][`SAPC_F_MODE];
      end
      cd_flag_insert <= cfg_q[0][`SAPC_F_CDINS];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags
  logic [31:0] set1, clr1, set2, clr2;

  // event seen in status one cycle later
  always_comb begin
    set1 = 32'h00000000;
    set1[`SAPC_B_DIN1F] = evt.data_in_full[0];
    set1[`SAPC_B_DIN2F] = evt.data_in_full[1];
    set1[`SAPC_B_DIN3F] = evt.data_in_full[2];
    // zero source masks the FIFO exceptions of ports 1 and 2 only
    set1[`SAPC_B_TXE1] = evt.tx_empty[0] && !src_zero[0];
    set1[`SAPC_B_TXE2] = evt.tx_empty[1] && !src_zero[1];
    set1[`SAPC_B_TXE3] = evt.tx_empty[2];
    set1[`SAPC_B_DIN3R] = evt.data_in_resync[2];
    set1[`SAPC_B_RX2ERR] = |evt.rx2_uq_combined_err;
    set1[`SAPC_B_TICK] = evt.tick_event;
    set1[`SAPC_B_DIN2R] = evt.data_in_resync[1];
    set1[`SAPC_B_DIN2UO] = evt.data_in_under_over[1];
    set1[`SAPC_B_DIN1R] = evt.data_in_resync[0];
    set1[`SAPC_B_DIN1UO] = evt.data_in_under_over[0];
    set1[`SAPC_B_UQERR] = evt.rx1_uq_frame_err;
    set1[`SAPC_B_UQSYNC] = evt.rx1_uq_sync;
    set1[`SAPC_B_QOVR] = evt.rx1_q_overrun;
    set1[`SAPC_B_QFULL] = evt.rx1_q_full;
    set1[`SAPC_B_UOVR] = evt.rx1_u_overrun;
    clr1 = 32'h00000000;
    if (wr && addr == `SAPC_A_ICLR1) begin
      clr1 = wdata & `SAPC_CLR1_MASK;
    end
    clr1[`SAPC_B_DIN1F] = rd_din1;
    clr1[`SAPC_B_DIN2F] = rd_din2;
    clr1[`SAPC_B_DIN3F] = rd_din3;
    clr1[`SAPC_B_TXE1] = tx_fifo_wr[0];
    clr1[`SAPC_B_TXE2] = tx_fifo_wr[1];
    clr1[`SAPC_B_TXE3] = tx_fifo_wr[2];
    clr1[`SAPC_B_QFULL] = rd_q1;
  end

  always_comb begin
    set2 = 32'h00000000;
    set2[`SAPC_B_CNEW2] = evt.rx2_new_c_channel;
    set2[`SAPC_B_VAL2] = evt.rx2_validity_clear;
    set2[`SAPC_B_SYM2] = evt.rx2_symbol_err;
    set2[`SAPC_B_PAR2] = evt.rx2_parity_err;
    set2[`SAPC_B_UFULL2] = evt.rx2_u_full;
    set2[`SAPC_B_UOVR] = evt.rx2_u_overrun;
    set2[`SAPC_B_QFULL] = evt.rx2_q_full;
    set2[`SAPC_B_QOVR] = evt.rx2_q_overrun;
    set2[`SAPC_B_UQSYNC] = evt.rx2_uq_sync;
    set2[`SAPC_B_UQERR] = evt.rx2_uq_frame_err;
    clr2 = 32'h00000000;
    if (wr && addr == `SAPC_A_ICLR2) begin
      clr2 = wdata & `SAPC_CLR2_MASK;
    end
    clr2[`SAPC_B_UFULL2] = rd_u2;
    clr2[`SAPC_B_QFULL] = rd_q2;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat1_q <= 32'h00000000;
      stat2_q <= 32'h00000000;
    end else begin
      // set or-ed last: events never lost
      stat1_q <= ((stat1_q & ~clr1) | set1) & `SAPC_STAT1_MASK;
      stat2_q <= ((stat2_q & ~clr2) | set2) & `SAPC_STAT2_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_req1 <= 32'h00000000;
      irq_req2 <= 32'h00000000;
    end else begin
      // requests lag status by one cycle
      irq_req1 <= stat1_q & ien1_q;
      irq_req2 <= stat2_q & ien2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit and word clock per port
  logic [NCLK-1:0] sclk_r, word_clock_r, fall_r;
  logic [5:0] bitcnt_q [NCLK];
  logic [5:0] half_w [NCLK];

  // ratio per clock select code
  function automatic logic [4:0] div_of(input logic [3:0] sel);
    unique case (sel)
      4'h1: div_of = `SAPC_DV24;
      4'h2: div_of = `SAPC_DV16;
      4'h3: div_of = `SAPC_DV12;
      4'h4: div_of = `SAPC_DV8;
      4'h5: div_of = `SAPC_DV6;
      4'h6: div_of = `SAPC_DV4;
      4'h7: div_of = `SAPC_DV3;
      default: div_of = `SAPC_DV2;
    endcase
  endfunction

  for (genvar i = 0; i < NCLK; i++) begin : g_clk
    logic [3:0] csel;
    logic [2:0] bpw;
    logic wcinv, is_int, is_fol;
    logic [1:0] fsel;
    logic s1_q, s2_q, s3_q, l1_q, l2_q, l3_q;
    logic [4:0] cnt_q, div, nxt, high;
    assign csel = cfg_q[i][`SAPC_F_CSEL +: 4];
    assign bpw = cfg_q[i][`SAPC_F_BPW +: 3];
    assign wcinv = cfg_q[i][`SAPC_F_WCINV];
    assign is_int = (csel >= 4'h1 && csel <= 4'h7) || csel == `SAPC_CSEL_DIV2;
    assign is_fol = csel >= `SAPC_CSEL_FOL1 && csel <= `SAPC_CSEL_FOL3;
    assign fsel = csel[1:0];
    assign div = div_of(csel);
    assign high = div - {1'b0, div[4:1]};
    assign nxt = (cnt_q >= div - 5'h01) ? 5'h00 : cnt_q + 5'h01;
    // unlisted codes run as 32 bits per word clock
    assign half_w[i] = (bpw == `SAPC_BPW_64) ? `SAPC_HALF_64 :
                       (bpw == `SAPC_BPW_48) ? `SAPC_HALF_48 : `SAPC_HALF_32;

    // pins are asynchronous; only the second and third stages feed logic
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        {s1_q, s2_q, s3_q, l1_q, l2_q, l3_q} <= 6'h00;
      end else begin
        {s1_q, s2_q, s3_q} <= {sclk_in[i], s1_q, s2_q};
        {l1_q, l2_q, l3_q} <= {word_clock_in[i], l1_q, l2_q};
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        cnt_q <= 5'h00;
        sclk_r[i] <= 1'b0;
        fall_r[i] <= 1'b0;
      end else if (csel == `SAPC_CSEL_EXT) begin
        sclk_r[i] <= s2_q;
        fall_r[i] <= s3_q && !s2_q;
      end else if (is_fol) begin
        // follows the other port one cycle late, so no loop forms
        sclk_r[i] <= sclk_r[fsel];
        fall_r[i] <= fall_r[fsel];
      end else if (is_int) begin
        fall_r[i] <= audio_ce && sclk_r[i] && nxt >= high;
        if (audio_ce) begin
          cnt_q <= nxt;
          sclk_r[i] <= nxt < high;
        end
      end else begin
        fall_r[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        word_clock_r[i] <= 1'b0;
        bitcnt_q[i] <= 6'h00;
      end else if (csel == `SAPC_CSEL_EXT) begin
        word_clock_r[i] <= l2_q ^ wcinv;
        if (l3_q != l2_q) begin
          bitcnt_q[i] <= 6'h00;
        end else if (fall_r[i]) begin
          bitcnt_q[i] <= bitcnt_q[i] + 6'h01;
        end
      end else if (is_fol) begin
        word_clock_r[i] <= word_clock_r[fsel];
        bitcnt_q[i] <= bitcnt_q[fsel];
      end else if (is_int && fall_r[i]) begin
        if (bitcnt_q[i] >= half_w[i] - 6'h01) begin
          bitcnt_q[i] <= 6'h00;
          word_clock_r[i] <= !word_clock_r[i];
        end else begin
          bitcnt_q[i] <= bitcnt_q[i] + 6'h01;
        end
      end
    end

    // master: inverted out and back in, so the datapath sees word_clock_r
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pins[i] <= '0;
        word_clock[i] <= 1'b0;
        bit_fall[i] <= 1'b0;
      end else begin
        pins[i].sclk_o <= sclk_r[i];
        pins[i].sclk_oe <= csel != `SAPC_CSEL_EXT;
        pins[i].word_clock_o <= word_clock_r[i] ^ wcinv;
        pins[i].word_clock_oe <= csel != `SAPC_CSEL_EXT && i < 3;
        word_clock[i] <= word_clock_r[i];
        bit_fall[i] <= fall_r[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // correction flag capture, port 1 receiver
  logic cf1_q, cf2_q;
  logic [5:0] cf_at;

  // counted in falls since word clock edge
  assign cf_at = cfg_q[0][`SAPC_F_CFPOS] ? half_w[0] - `SAPC_CF_BEFORE : `SAPC_CF_AFTER;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cf1_q <= 1'b0;
      cf2_q <= 1'b0;
      correction_flag_q <= 1'b0;
    end else begin
      cf1_q <= correction_flag_in;
      cf2_q <= cf1_q;
      if (cfg_q[0][`SAPC_F_CDINS] && fall_r[0] && bitcnt_q[0] == cf_at) begin
        correction_flag_q <= cf2_q;
      end
    end
  end

endmodule // sapc_top

// ### tb/sapc_properties.sv
`timescale 1ns/10ps
`include "sapc_regs.svh"
module sapc_properties #(
  parameter int NCLK = 4,
  parameter int NTX = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire sapc_pkg::sapc_pins_t [NCLK-1:0] pins,
  input wire logic [NCLK-1:0] bit_fall,
  input wire logic correction_flag_q,
  input wire logic cd_flag_insert,
  input wire logic [2:0] tx_fifo_wr,
  input wire logic [NTX-1:0] tx_fifo_reset,
  input wire logic [NTX-1:0] tx_zero,
  input wire logic [NTX-1:0][3:0] transmit_source_select,
  input wire logic [2:0] port_zero,
  input wire logic [2:0] port_eiaj,
  input wire logic [31:0] irq_req1,
  input wire logic [31:0] irq_req2
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rdata_idle; !$past(rd) |-> rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_unmapped; $past(rd) && $past(addr) == 8'h00 |-> rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cfg_mask;
    $past(rd) && $past(addr) == `SAPC_A_CFG1 |-> (rdata & ~`SAPC_CFG_MASK) == 32'h0;
  endproperty
  a_cfg_mask: assert property (p_cfg_mask) else $error("reserved config bits set");
  property p_fifo_release; $fell(tx_fifo_reset[0]) |-> $past(tx_fifo_wr[0], 2); endproperty
  a_fifo_release: assert property (p_fifo_release) else $error("fifo left reset unwritten");
  property p_fifo_hold;
    $rose(tx_fifo_reset[0]) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("fifo reset without write");
  property p_zero_src; tx_zero[0] == (transmit_source_select[0] == 4'h0); endproperty
  a_zero_src: assert property (p_zero_src) else $error("zero flag disagrees with source");
  property p_fall_pulse; bit_fall[0] |=> !bit_fall[0]; endproperty
  a_fall_pulse: assert property (p_fall_pulse) else $error("bit fall longer than a cycle");
  property p_no_wc_out3; !pins[3].word_clock_oe; endproperty
  a_no_wc_out3: assert property (p_no_wc_out3) else $error("fourth port drives word clock");
  property p_cfg_stable;
    !$past(wr) && !$past(wr, 2) |-> $stable(port_zero) && $stable(port_eiaj);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("mode or size moved alone");
  property p_cd_off; !cd_flag_insert [*3] |-> $stable(correction_flag_q); endproperty
  a_cd_off: assert property (p_cd_off) else $error("flag sampled while insert off");
  property p_irq_mask;
    (irq_req1 & ~`SAPC_STAT1_MASK) == 32'h0 && (irq_req2 & ~`SAPC_STAT2_MASK) == 32'h0;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("request on unused status bit");
  c_fifo_run: cover property ($fell(tx_fifo_reset[0]));
  c_bit_fall: cover property (bit_fall[0]);
  c_irq: cover property (irq_req1 != 32'h0);
endmodule // sapc_properties

bind sapc_top sapc_properties #(.NCLK(NCLK), .NTX(NTX)) u_sapc_properties (
  .clk(clk), .nrst(nrst), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .pins(pins),
  .bit_fall(bit_fall), .correction_flag_q(correction_flag_q), .cd_flag_insert(cd_flag_insert),
  .tx_fifo_wr(tx_fifo_wr), .tx_fifo_reset(tx_fifo_reset), .tx_zero(tx_zero),
  .transmit_source_select(transmit_source_select), .port_zero(port_zero),
  .port_eiaj(port_eiaj), .irq_req1(irq_req1), .irq_req2(irq_req2));

// ### tb/sapc_ext_clock_model.sv
`timescale 1ns/10ps
module sapc_ext_clock_model #(
  parameter int HALF = 4,
  parameter int BITS_HALF = 16
) (
  input wire logic clk,
  input wire logic run,
  output logic sclk,
  output logic word_clock,
  output logic flag
);
  int ph = 0;
  int nb = 0;
  initial begin
    sclk = 1'b0;
    word_clock = 1'b1;
    flag = 1'b0;
  end
  always @(posedge clk) begin
    if (!run) begin
      // bit clock idles low between frames
      sclk <= 1'b0;
      flag <= ~flag;
      ph <= 0;
    end else if (ph == HALF - 1) begin
      ph <= 0;
      sclk <= ~sclk;
      if (sclk) begin
        flag <= ~flag;
        if (nb == BITS_HALF - 1) begin
          nb <= 0;
          word_clock <= ~word_clock;
        end else begin
          nb <= nb + 1;
        end
      end
    end else begin
      ph <= ph + 1;
    end
  end
endmodule // sapc_ext_clock_model

// ### tb/serial_audio_port_config_tb.sv
`timescale 1ns/10ps
`include "sapc_regs.svh"
module serial_audio_port_config_tb;
  logic clk, nrst, audio_ce, wr, rd, ext_run, ext_sclk, ext_wc, ext_flag, cfq, cd_ins;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, irq_req1, irq_req2;
  logic [3:0] word_clock, bit_fall;
  logic [2:0] tx_fifo_wr, port_zero, port_eiaj;
  logic [1:0] tx_fifo_reset, tx_zero;
  logic [1:0][3:0] src_sel;
  sapc_pkg::sapc_pins_t [3:0] pins;
  sapc_pkg::sapc_evt_t evt, ev;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  int dv[8] = '{24, 16, 12, 8, 6, 4, 3, 2};

  sapc_top #(.NCLK(4), .NTX(2)) u_sapc_top (
    .clk(clk), .nrst(nrst), .audio_ce(audio_ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sclk_in({4{ext_sclk}}), .word_clock_in({4{ext_wc}}),
    .pins(pins), .word_clock(word_clock), .bit_fall(bit_fall), .correction_flag_in(ext_flag),
    .correction_flag_q(cfq), .cd_flag_insert(cd_ins), .evt(evt), .tx_fifo_wr(tx_fifo_wr),
    .tx_fifo_reset(tx_fifo_reset), .tx_zero(tx_zero), .transmit_source_select(src_sel),
    .port_zero(port_zero), .port_eiaj(port_eiaj), .irq_req1(irq_req1), .irq_req2(irq_req2));
  sapc_ext_clock_model u_sapc_ext_clock_model (
    .clk(clk), .run(ext_run), .sclk(ext_sclk), .word_clock(ext_wc), .flag(ext_flag));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      $display("timeout");
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_count(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      num_errors++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic touch(input logic [7:0] a);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    touch(a);
    #1 chk($sformatf("register %h", a), exp, rdata);
  endtask
  task automatic pulse(input sapc_pkg::sapc_evt_t e, input logic [2:0] w);
    @(posedge clk); evt <= e; tx_fifo_wr <= w;
    @(posedge clk); evt <= '0; tx_fifo_wr <= 3'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // cycles between the second and third event; the first interval may be partial
  task automatic gap(input int idx, input bit use_wc, output int len);
    int ev_n;
    logic w0;
    ev_n = 0;
    len = 0;
    w0 = word_clock[idx];
    for (int i = 0; i < 2000 && ev_n < 3; i++) begin
      @(posedge clk); #1; len++;
      if (use_wc ? (word_clock[idx] !== w0) : (bit_fall[idx] === 1'b1)) begin
        ev_n++;
        if (ev_n < 3) len = 0;
      end
      w0 = word_clock[idx];
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0; audio_ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
    evt = '0; tx_fifo_wr = 3'h0; ext_run = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rreg(`SAPC_A_CFG1, `SAPC_CFG_RESET);
    rreg(`SAPC_A_CFG2, `SAPC_CFG_RESET);
    rreg(`SAPC_A_CFG3, `SAPC_CFG_RESET);
    rreg(8'h00, 32'h0);
    chk("fifo reset", 32'h3, {30'h0, tx_fifo_reset});
    chk("tx zero", 32'h3, {30'h0, tx_zero});
    wreg(`SAPC_A_CFG1, 32'hFFFFFFFF);
    rreg(`SAPC_A_CFG1, `SAPC_CFG_MASK);
    wreg(`SAPC_A_CFG4, 32'hFFFFFFFF);
    rreg(`SAPC_A_CFG4, `SAPC_CFG4_MASK);
    $display("done: reset and register layout");
    for (int i = 0; i < 4; i++) begin
      wreg(`SAPC_A_CFG2, 32'h800 | (32'(i) << 6) | (32'(i & 1) << 5));
      repeat (2) @(posedge clk); #1;
      chk("port zero", 32'(i == 3), {31'h0, port_zero[1]});
      chk("framing", 32'(i & 1), {31'h0, port_eiaj[1]});
    end
    for (int i = 0; i < 9; i++) begin
      if (i != 6) begin
        wreg(`SAPC_A_CFG1, 32'h800 | (32'(i & 7) << 8) | (32'(i >> 3) << 16));
        repeat (2) @(posedge clk); #1;
        chk("source", 32'(i), {28'h0, src_sel[0]});
        chk("zero source", 32'(i == 0), {31'h0, tx_zero[0]});
      end
    end
    $display("done: modes and sources");
    wreg(`SAPC_A_CFG1, 32'h100);
    repeat (8) @(posedge clk); #1;
    chk("fifo armed", 32'h1, {31'h0, tx_fifo_reset[0]});
    pulse('0, 3'h1);
    chk("fifo running", 32'h0, {31'h0, tx_fifo_reset[0]});
    wreg(`SAPC_A_CFG1, 32'h900);
    repeat (3) @(posedge clk); #1;
    chk("fifo held", 32'h1, {31'h0, tx_fifo_reset[0]});
    wreg(`SAPC_A_CFG2, 32'h900);
    $display("done: fifo control");
    ev = '0;
    ev.data_in_full = 3'h7; ev.tx_empty = 3'h7; ev.data_in_under_over = 2'h3;
    ev.data_in_resync = 3'h7; ev.tick_event = 1'b1; ev.rx1_u_overrun = 1'b1;
    ev.rx1_q_full = 1'b1; ev.rx1_q_overrun = 1'b1; ev.rx1_uq_sync = 1'b1;
    ev.rx1_uq_frame_err = 1'b1; ev.rx2_uq_combined_err = 3'h1;
    pulse(ev, 3'h0);
    rreg(`SAPC_A_ISTAT1, `SAPC_STAT1_MASK);
    wreg(`SAPC_A_ICLR1, 32'hFFFFFFFF);
    rreg(`SAPC_A_ISTAT1, `SAPC_STAT1_MASK & ~`SAPC_CLR1_MASK);
    touch(`SAPC_A_DIN1L);
    touch(`SAPC_A_DIN2);
    touch(`SAPC_A_DIN3L);
    touch(`SAPC_A_QRX1);
    rreg(`SAPC_A_ISTAT1, 32'h1C);
    pulse('0, 3'h7);
    rreg(`SAPC_A_ISTAT1, 32'h0);
    ev = '0;
    ev.tick_event = 1'b1;
    pulse(ev, 3'h0);
    // clear request and a fresh event land on the same edge
    @(posedge clk); wr <= 1'b1; addr <= `SAPC_A_ICLR1; wdata <= 32'h100; evt <= ev;
    @(posedge clk); wr <= 1'b0; evt <= '0;
    rreg(`SAPC_A_ISTAT1, 32'h100);
    wreg(`SAPC_A_IEN1, 32'h100);
    repeat (2) @(posedge clk); #1;
    chk("request enabled", 32'h100, irq_req1);
    wreg(`SAPC_A_IEN1, 32'h0);
    repeat (2) @(posedge clk); #1;
    chk("request masked", 32'h0, irq_req1);
    ev = '0;
    ev.rx2_new_c_channel = 1'b1; ev.rx2_validity_clear = 1'b1; ev.rx2_symbol_err = 1'b1;
    ev.rx2_parity_err = 1'b1; ev.rx2_u_full = 1'b1; ev.rx2_u_overrun = 1'b1;
    ev.rx2_q_full = 1'b1; ev.rx2_q_overrun = 1'b1; ev.rx2_uq_sync = 1'b1;
    ev.rx2_uq_frame_err = 1'b1;
    pulse(ev, 3'h0);
    rreg(`SAPC_A_ISTAT2, `SAPC_STAT2_MASK);
    wreg(`SAPC_A_IEN2, 32'h02000000);
    repeat (2) @(posedge clk); #1;
    chk("second request", 32'h02000000, irq_req2);
    wreg(`SAPC_A_ICLR2, 32'hFFFFFFFF);
    rreg(`SAPC_A_ISTAT2, `SAPC_STAT2_MASK & ~`SAPC_CLR2_MASK);
    touch(`SAPC_A_URX2);
    touch(`SAPC_A_QRX2);
    rreg(`SAPC_A_ISTAT2, 32'h0);
    $display("done: status flags");
    // clock select changes only with the fifo held, hence bit 11 in every write
    for (int i = 0; i < 8; i++) begin
      wreg(`SAPC_A_CFG1, 32'h800 | (32'((i < 7) ? i + 1 : 12) << 12));
      gap(0, 1'b0, n);
      chk_count("bit clock period", dv[i], n);
    end
    chk("bit clock driven", 32'h1, {31'h0, pins[0].sclk_oe});
    chk("word clock driven", 32'h1, {31'h0, pins[0].word_clock_oe});
    for (int i = 0; i < 3; i++) begin
      wreg(`SAPC_A_CFG1, 32'h6800 | (32'(2 * i) << 2));
      gap(0, 1'b1, n);
      chk_count("word clock half", 4 * (16 + 8 * i), n);
    end
    wreg(`SAPC_A_CFG2, 32'h8900);
    gap(1, 1'b0, n);
    chk_count("follow period", 4, n);
    $display("done: internal clocks");
    @(posedge clk) ext_run <= 1'b1;
    gap(2, 1'b0, n);
    chk_count("external bit period", 8, n);
    gap(2, 1'b1, n);
    chk_count("external word half", 128, n);
    chk("external not driven", 32'h0, {31'h0, pins[2].sclk_oe});
    @(posedge clk) ext_run <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wreg(`SAPC_A_CFG3, 32'h800 | (32'(i) << 1));
      repeat (6) @(posedge clk); #1;
      chk("word clock level", {31'h0, ext_wc ^ i[0]}, {31'h0, word_clock[2]});
    end
    wreg(`SAPC_A_CFG1, 32'h40800);
    repeat (2) @(posedge clk); #1;
    chk("flag insert on", 32'h1, {31'h0, cd_ins});
    wreg(`SAPC_A_CFG1, 32'h800);
    repeat (2) @(posedge clk); #1;
    chk("flag insert off", 32'h0, {31'h0, cd_ins});
    $display("done: external clocks and flag insert");
    tally_and_finish();
  end
endmodule // serial_audio_port_config_tb
